// File: verilog/tcm_pkg.sv
// Shared constants and helpers for the capture/reload timer block
package tcm_pkg;

  localparam int TCM_AW = 3;
  localparam int TCM_DW = 16;

  // Register offsets (word index on the plain register port)
  localparam logic [2:0] TCM_OFF_CTRL = 3'h0;
  localparam logic [2:0] TCM_OFF_TMR = 3'h1;
  localparam logic [2:0] TCM_OFF_RA = 3'h2;
  localparam logic [2:0] TCM_OFF_RB = 3'h3;
  localparam logic [2:0] TCM_OFF_CMP = 3'h4;

  // Control register field positions
  localparam int TCM_BIT_ENB = 0;
  localparam int TCM_BIT_PNDB = 1;
  localparam int TCM_BIT_ENA = 2;
  localparam int TCM_BIT_PNDA = 3;
  localparam int TCM_BIT_RUN = 4;
  localparam int TCM_BIT_MODE = 5;
  localparam int TCM_MODE_W = 3;

  // Comparator routing register field positions
  localparam int TCM_BIT_COMPARATOR_ENABLE = 0;
  localparam int TCM_BIT_ROUTE = 1;

  // Reset values
  localparam logic [2:0] TCM_RST_MODE = 3'h0;
  localparam logic [15:0] TCM_RST_TMR = 16'h0000;
  localparam logic [15:0] TCM_RST_RELOAD = 16'h0000;

  // Mode codes
  localparam logic [2:0] TCM_CODE_PWM_TGL = 3'h5;
  localparam logic [2:0] TCM_CODE_PWM = 3'h4;
  localparam logic [2:0] TCM_CODE_EVT0 = 3'h0;
  localparam logic [2:0] TCM_CODE_EVT1 = 3'h1;
  localparam logic [2:0] TCM_CODE_CAP_RR = 3'h2;
  localparam logic [2:0] TCM_CODE_CAP_RF = 3'h6;
  localparam logic [2:0] TCM_CODE_CAP_FF0 = 3'h3;
  localparam logic [2:0] TCM_CODE_CAP_FF1 = 3'h7;

  typedef enum logic [1:0] {TCM_M_PWM, TCM_M_EVT, TCM_M_CAP} tcm_mode_t;

  function automatic tcm_mode_t tcm_decode(input logic [2:0] code);
    tcm_mode_t m;
    m = TCM_M_CAP;
    unique case (code)
      TCM_CODE_PWM_TGL, TCM_CODE_PWM: m = TCM_M_PWM;
      TCM_CODE_EVT0, TCM_CODE_EVT1: m = TCM_M_EVT;
      TCM_CODE_CAP_RR, TCM_CODE_CAP_RF, TCM_CODE_CAP_FF0, TCM_CODE_CAP_FF1: m = TCM_M_CAP;
    endcase
    return m;
  endfunction

endpackage

// File: verilog/tcm_edge_if.sv
// Edge pulses passed from the pin front end to the timer core
`timescale 1ns/1ps
`default_nettype none
interface tcm_edge_if;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  logic b_route;
  modport src (output a_rise, output a_fall, output b_rise, output b_fall, input b_route);
  modport dst (input a_rise, input a_fall, input b_rise, input b_fall, output b_route);
endinterface
`default_nettype wire

// File: verilog/tcm_edge_sync.sv
// Pin synchronisers, capture-B source select and edge detection
`timescale 1ns/1ps
`default_nettype none
module tcm_edge_sync
  import tcm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic cmp_out,
  tcm_edge_if.src edge_o
);

  typedef struct packed {
    logic a_s1;
    logic a_s2;
    logic a_d;
    logic b_s1;
    logic b_s2;
    logic c_s1;
    logic c_s2;
    logic b_d;
  } tcm_sync_t;

  tcm_sync_t q_ff;
  tcm_sync_t nxt_q;
  logic b_sel;

  always_comb begin
    nxt_q = q_ff;
    nxt_q.a_s1 = pin_a;
    nxt_q.a_s2 = q_ff.a_s1;
    nxt_q.a_d = q_ff.a_s2;
    nxt_q.b_s1 = pin_b;
    nxt_q.b_s2 = q_ff.b_s1;
    nxt_q.c_s1 = cmp_out;
    nxt_q.c_s2 = q_ff.c_s1;
    // Mux after sync; a route change may show as one edge
    b_sel = edge_o.b_route ? q_ff.c_s2 : q_ff.b_s2;
    nxt_q.b_d = b_sel;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign edge_o.a_rise = q_ff.a_s2 & ~q_ff.a_d;
  assign edge_o.a_fall = ~q_ff.a_s2 & q_ff.a_d;
  assign edge_o.b_rise = b_sel & ~q_ff.b_d;
  assign edge_o.b_fall = ~b_sel & q_ff.b_d;

endmodule
`default_nettype wire

// File: verilog/tcm_timer.sv
// Multifunction 16-bit timer: PWM, event counter and input capture
`timescale 1ns/1ps
`default_nettype none
module tcm_timer
  import tcm_pkg::*;
#(
  parameter bit HAS_CMP_ROUTE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [TCM_AW-1:0] reg_addr,
  input wire logic [TCM_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [TCM_DW-1:0] reg_rdata,
  input wire logic timer_pin_a_i,
  output logic timer_pin_a_o,
  output logic timer_pin_a_oe,
  input wire logic timer_pin_b,
  input wire logic comparator_out,
  output logic irq_a,
  output logic irq_b
);

  typedef struct packed {
    logic [15:0] tmr;
    logic [15:0] ra;
    logic [15:0] rb;
    logic [2:0] mode_sel;
    logic run_or_underflow_pending;
    logic pending_flag_a;
    logic irq_enable_a;
    logic pending_flag_b;
    logic irq_enable_b;
    logic reload_b;
    logic pin_a;
    logic comparator_enable;
    logic comparator_to_capture_route;
    logic [15:0] rdata;
  } tcm_state_t;

  tcm_state_t q_ff;
  tcm_state_t nxt_q;
  tcm_edge_if edge_bus ();

  tcm_mode_t mode;
  logic tick;
  logic uf;
  logic ev_pnda;
  logic ev_pndb;
  logic ev_upnd;
  logic cap_a;
  logic cap_b;
  logic [15:0] hw_tmr;
  logic [15:0] ctrl_rd;
  logic [15:0] cmp_rd;

  tcm_edge_sync u_edge (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pin_a(timer_pin_a_i),
    .pin_b(timer_pin_b),
    .cmp_out(comparator_out),
    .edge_o(edge_bus.src)
  );

  // Route only while the comparator itself is on
  assign edge_bus.b_route = HAS_CMP_ROUTE & q_ff.comparator_to_capture_route
                            & q_ff.comparator_enable;

  always_comb begin
    nxt_q = q_ff;
    mode = tcm_decode(q_ff.mode_sel);
    tick = 1'b0;
    ev_pnda = 1'b0;
    ev_pndb = 1'b0;
    ev_upnd = 1'b0;
    cap_a = 1'b0;
    cap_b = 1'b0;

    unique case (mode)
      TCM_M_PWM: tick = q_ff.run_or_underflow_pending;
      TCM_M_EVT: tick = q_ff.run_or_underflow_pending & edge_bus.a_rise;
      TCM_M_CAP: tick = 1'b1;
    endcase
    uf = tick & (q_ff.tmr == 16'h0000);
    hw_tmr = tick ? q_ff.tmr - 16'h0001 : q_ff.tmr;

    unique case (mode)
      TCM_M_PWM: begin
        if (uf) begin
          // First underflow after start reloads from A
          hw_tmr = q_ff.reload_b ? q_ff.rb : q_ff.ra;
          ev_pnda = ~q_ff.reload_b;
          ev_pndb = q_ff.reload_b;
          nxt_q.reload_b = ~q_ff.reload_b;
          if (q_ff.mode_sel == TCM_CODE_PWM_TGL) begin
            nxt_q.pin_a = ~q_ff.pin_a;
          end
        end
        if (!q_ff.run_or_underflow_pending) begin
          nxt_q.reload_b = 1'b0;
        end
      end
      TCM_M_EVT: begin
        if (uf) begin
          hw_tmr = q_ff.ra;
          ev_pnda = 1'b1;
        end
        ev_pndb = edge_bus.b_rise;
        nxt_q.reload_b = 1'b0;
      end
      TCM_M_CAP: begin
        // Counter wraps through ffff; no reload in this mode
        ev_upnd = uf;
        unique case (q_ff.mode_sel)
          TCM_CODE_CAP_RR: begin
            cap_a = edge_bus.a_rise;
            cap_b = edge_bus.b_rise;
          end
          TCM_CODE_CAP_RF: begin
            cap_a = edge_bus.a_rise;
            cap_b = edge_bus.b_fall;
          end
          default: begin
            // Codes 011 and 111 only reach here
            cap_a = edge_bus.a_fall;
            cap_b = edge_bus.b_fall;
          end
        endcase
        ev_pnda = cap_a;
        ev_pndb = cap_b;
        nxt_q.reload_b = 1'b0;
      end
    endcase

    nxt_q.tmr = hw_tmr;
    if (mode != TCM_M_PWM) begin
      nxt_q.pin_a = 1'b0;
    end

    // Software writes first; hardware events are layered on top
    if (reg_wr) begin
      unique case (reg_addr)
        TCM_OFF_CTRL: begin
          nxt_q.mode_sel = reg_wdata[TCM_BIT_MODE +: TCM_MODE_W];
          nxt_q.run_or_underflow_pending = reg_wdata[TCM_BIT_RUN];
          nxt_q.pending_flag_a = reg_wdata[TCM_BIT_PNDA];
          nxt_q.irq_enable_a = reg_wdata[TCM_BIT_ENA];
          nxt_q.pending_flag_b = reg_wdata[TCM_BIT_PNDB];
          nxt_q.irq_enable_b = reg_wdata[TCM_BIT_ENB];
        end
        TCM_OFF_TMR: nxt_q.tmr = reg_wdata;
        TCM_OFF_RA: nxt_q.ra = reg_wdata;
        TCM_OFF_RB: nxt_q.rb = reg_wdata;
        TCM_OFF_CMP: begin
          nxt_q.comparator_enable = reg_wdata[TCM_BIT_COMPARATOR_ENABLE];
          nxt_q.comparator_to_capture_route = reg_wdata[TCM_BIT_ROUTE];
        end
        default: begin
        end
      endcase
    end

    // A capture overrides a same-cycle software write to its register
    if (cap_a) begin
      nxt_q.ra = q_ff.tmr;
    end
    if (cap_b) begin
      nxt_q.rb = q_ff.tmr;
    end
    // Set beats clear; nothing here clears a flag on its own
    nxt_q.pending_flag_a = nxt_q.pending_flag_a | ev_pnda;
    nxt_q.pending_flag_b = nxt_q.pending_flag_b | ev_pndb;
    nxt_q.run_or_underflow_pending = nxt_q.run_or_underflow_pending | ev_upnd;

    ctrl_rd = '0;
    ctrl_rd[TCM_BIT_MODE +: TCM_MODE_W] = q_ff.mode_sel;
    ctrl_rd[TCM_BIT_RUN] = q_ff.run_or_underflow_pending;
    ctrl_rd[TCM_BIT_PNDA] = q_ff.pending_flag_a;
    ctrl_rd[TCM_BIT_ENA] = q_ff.irq_enable_a;
    ctrl_rd[TCM_BIT_PNDB] = q_ff.pending_flag_b;
    ctrl_rd[TCM_BIT_ENB] = q_ff.irq_enable_b;
    cmp_rd = '0;
    cmp_rd[TCM_BIT_COMPARATOR_ENABLE] = q_ff.comparator_enable;
    cmp_rd[TCM_BIT_ROUTE] = q_ff.comparator_to_capture_route;

    // Read data stand for one cycle only, zero otherwise
    nxt_q.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        TCM_OFF_CTRL: nxt_q.rdata = ctrl_rd;
        TCM_OFF_TMR: nxt_q.rdata = q_ff.tmr;
        TCM_OFF_RA: nxt_q.rdata = q_ff.ra;
        TCM_OFF_RB: nxt_q.rdata = q_ff.rb;
        TCM_OFF_CMP: nxt_q.rdata = cmp_rd;
        default: nxt_q.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= '0;
      q_ff.tmr <= TCM_RST_TMR;
      q_ff.ra <= TCM_RST_RELOAD;
      q_ff.rb <= TCM_RST_RELOAD;
      q_ff.mode_sel <= TCM_RST_MODE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign reg_rdata = q_ff.rdata;
  assign timer_pin_a_o = q_ff.pin_a;
  assign timer_pin_a_oe = (tcm_decode(q_ff.mode_sel) == TCM_M_PWM);
  // Underflow joins interrupt A only in capture mode
  assign irq_a = q_ff.irq_enable_a & (q_ff.pending_flag_a
                 | ((tcm_decode(q_ff.mode_sel) == TCM_M_CAP)
                    & q_ff.run_or_underflow_pending));
  assign irq_b = q_ff.irq_enable_b & q_ff.pending_flag_b;

endmodule
`default_nettype wire

// File: verif/tcm_timer_checker.sv
// Port-level assertions for the capture/reload timer
`timescale 1ns/1ps
`default_nettype none
module tcm_timer_checker
  import tcm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [TCM_AW-1:0] reg_addr,
  input wire logic [TCM_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [TCM_DW-1:0] reg_rdata,
  input wire logic timer_pin_a_o,
  input wire logic timer_pin_a_oe,
  input wire logic irq_a,
  input wire logic irq_b
);
  // Shadow of the bits only software can change: mode, ena, enb
  logic [4:0] sw_ff;
  wire cw = reg_wr && reg_addr == TCM_OFF_CTRL;
  wire rt = reg_rd && reg_addr == TCM_OFF_TMR;
  wire cap = sw_ff[3];
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sw_ff <= 5'h00;
    end else if (cw) begin
      sw_ff <= {reg_wdata[7:5], reg_wdata[2], reg_wdata[0]};
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its slot");
  a_oe_pwm: assert property (timer_pin_a_oe == (sw_ff[4:3] == 2'b10))
    else $error("pin A enable disagrees with mode");
  a_pin_quiet: assert property (!timer_pin_a_oe [*2] |-> !timer_pin_a_o)
    else $error("pin A output active outside PWM");
  a_irqa_gate: assert property (irq_a |-> sw_ff[1])
    else $error("interrupt A without its enable");
  a_irqb_gate: assert property (irq_b |-> sw_ff[0])
    else $error("interrupt B without its enable");
  a_irqa_hold: assert property (irq_a && !cw |=> irq_a)
    else $error("interrupt A dropped without software");
  a_irqb_hold: assert property (irq_b && !cw |=> irq_b)
    else $error("interrupt B dropped without software");
  a_ctrl_read: assert property ($past(reg_rd && reg_addr == TCM_OFF_CTRL) |->
    {reg_rdata[7:5], reg_rdata[2], reg_rdata[0]} == sw_ff)
    else $error("control readback wrong");
  a_tmr_runs: assert property ($past(rt) && $past(rt, 2) && cap |->
    reg_rdata == $past(reg_rdata) - 16'h0001)
    else $error("capture timer not counting each tick");
  c_cap_irq: cover property (cap && $rose(irq_a));
  c_pwm_tgl: cover property (timer_pin_a_oe && $rose(timer_pin_a_o));
  c_irq_b: cover property ($rose(irq_b));
endmodule
bind tcm_timer tcm_timer_checker tcm_timer_checker_inst (.ref_clk, .rstn, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .timer_pin_a_o, .timer_pin_a_oe, .irq_a, .irq_b);
`default_nettype wire

// File: verif/tcm_pins_model.sv
// Far-side model: timer pins and comparator output
`timescale 1ns/1ps
`default_nettype none
module tcm_pins_model (
  input wire logic ref_clk,
  output var logic pin_a,
  output var logic pin_b,
  output var logic cmp_out
);
  initial {pin_a, pin_b, cmp_out} = 3'h0;
  // Levels move just after an edge, so each level lasts whole ticks
  task automatic drive(input logic [2:0] v);
    @(posedge ref_clk);
    {pin_a, pin_b, cmp_out} <= v;
  endtask
endmodule
`default_nettype wire

// File: verif/tcm_timer_tb.sv
// Self-checking bench for the capture/reload timer
`timescale 1ns/1ps
`default_nettype none
module tcm_timer_tb
  import tcm_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, d, e, n;
  logic reg_wr = 1'b0, reg_rd = 1'b0, pa, pb, cmp;
  logic timer_pin_a_o, timer_pin_a_oe, irq_a, irq_b;
  int fails = 0, checks = 0;
  // Pin A wire: the block wins while it drives
  wire pa_w = timer_pin_a_oe ? timer_pin_a_o : pa;
  initial forever #20 ref_clk = ~ref_clk;
  tcm_timer tcm_timer_inst (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .timer_pin_a_i(pa_w), .timer_pin_a_o, .timer_pin_a_oe,
    .timer_pin_b(pb), .comparator_out(cmp), .irq_a, .irq_b);
  tcm_pins_model tcm_pins_model_inst (.ref_clk, .pin_a(pa), .pin_b(pb), .cmp_out(cmp));
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    checks++;
    if (g !== x) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic pins(input logic [2:0] v);
    tcm_pins_model_inst.drive(v);
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // Let the write settle before anyone looks at outputs
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Cycles until pin A output changes, gives up at 255
  task automatic gap(output logic [15:0] c);
    logic p;
    p = timer_pin_a_o;
    c = 16'h0000;
    while (timer_pin_a_o === p && c < 16'h00ff) begin
      @(posedge ref_clk);
      #1 c++;
    end
  endtask
  task automatic t_reset();
    rd(TCM_OFF_CTRL, d);
    chk(d, 16'h0000);
    chk({14'h0, irq_a, irq_b}, 16'h0000);
    rd(3'h5, d);
    chk(d, 16'h0000);
  endtask
  task automatic t_event();
    wr(TCM_OFF_RA, 16'h0002);
    wr(TCM_OFF_TMR, 16'h0001);
    wr(TCM_OFF_CTRL, 16'h0035);
    repeat (2) begin
      pins(3'h4);
      repeat (3) @(posedge ref_clk);
      pins(3'h0);
      repeat (3) @(posedge ref_clk);
    end
    rd(TCM_OFF_TMR, d);
    chk(d, 16'h0002);
    rd(TCM_OFF_CTRL, d);
    chk({12'h0, d[3:0]}, 16'h000d);
    pins(3'h2);
    repeat (4) @(posedge ref_clk);
    rd(TCM_OFF_CTRL, d);
    chk({12'h0, d[3:0]}, 16'h000f);
    pins(3'h0);
  endtask
  task automatic t_capture(input logic [2:0] c);
    logic ar, br;
    ar = !c[0];
    br = (c == TCM_CODE_CAP_RR);
    pins({!ar, !br, 1'b0});
    repeat (6) @(posedge ref_clk);
    wr(TCM_OFF_CTRL, {8'h00, c, 5'h05});
    pins({ar, !br, 1'b0});
    repeat (19) @(posedge ref_clk);
    pins({ar, br, 1'b0});
    repeat (6) @(posedge ref_clk);
    // Returning edges have the other polarity and must not recapture
    pins({!ar, !br, 1'b0});
    repeat (6) @(posedge ref_clk);
    rd(TCM_OFF_RA, d);
    rd(TCM_OFF_RB, e);
    chk(d - e, 16'h0014);
    rd(TCM_OFF_CTRL, d);
    chk({12'h0, d[3:0]}, 16'h000f);
    chk({14'h0, irq_a, irq_b}, 16'h0003);
  endtask
  task automatic t_gate();
    wr(TCM_OFF_CTRL, 16'h004a);
    chk({14'h0, irq_a, irq_b}, 16'h0000);
    wr(TCM_OFF_CTRL, 16'h004f);
    repeat (10) @(posedge ref_clk);
    chk({14'h0, irq_a, irq_b}, 16'h0003);
    wr(TCM_OFF_CTRL, 16'h0045);
    chk({14'h0, irq_a, irq_b}, 16'h0000);
  endtask
  task automatic t_underflow();
    wr(TCM_OFF_CTRL, 16'h0044);
    wr(TCM_OFF_TMR, 16'h0003);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= TCM_OFF_TMR;
    @(posedge ref_clk);
    #1 d = reg_rdata;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 e = reg_rdata;
    chk(d - e, 16'h0001);
    repeat (8) @(posedge ref_clk);
    rd(TCM_OFF_CTRL, d);
    chk({11'h0, d[4:0]}, 16'h0014);
    chk({15'h0, irq_a}, 16'h0001);
  endtask
  task automatic t_pwm();
    wr(TCM_OFF_RA, 16'h0004);
    wr(TCM_OFF_RB, 16'h0009);
    // Clear the count after the mode change; capture mode would keep counting
    wr(TCM_OFF_CTRL, 16'h00b4);
    wr(TCM_OFF_TMR, 16'h0000);
    chk({15'h0, timer_pin_a_oe}, 16'h0001);
    gap(n);
    gap(n);
    chk(n, 16'h0005);
    gap(n);
    chk(n, 16'h000a);
    rd(TCM_OFF_CTRL, d);
    chk({12'h0, d[3:0]}, 16'h000e);
    wr(TCM_OFF_CTRL, 16'h00a4);
    rd(TCM_OFF_TMR, d);
    rd(TCM_OFF_TMR, e);
    chk(d - e, 16'h0000);
    wr(TCM_OFF_CTRL, 16'h0094);
    gap(n);
    chk(n, 16'h00ff);
  endtask
  task automatic t_cmp();
    pins(3'h0);
    wr(TCM_OFF_CTRL, 16'h0041);
    wr(TCM_OFF_CMP, 16'h0002);
    pins(3'h1);
    repeat (6) @(posedge ref_clk);
    rd(TCM_OFF_CTRL, d);
    chk({15'h0, d[1]}, 16'h0000);
    pins(3'h0);
    wr(TCM_OFF_CMP, 16'h0003);
    wr(TCM_OFF_CTRL, 16'h0041);
    pins(3'h1);
    repeat (6) @(posedge ref_clk);
    rd(TCM_OFF_CTRL, d);
    chk({15'h0, d[1]}, 16'h0001);
  endtask
  task automatic print_verdict();
    if (fails == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_event();
    t_capture(TCM_CODE_CAP_RF);
    t_capture(TCM_CODE_CAP_FF0);
    t_capture(TCM_CODE_CAP_FF1);
    t_capture(TCM_CODE_CAP_RR);
    t_gate();
    t_underflow();
    t_pwm();
    t_cmp();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end
endmodule
`default_nettype wire
